// File: design/fbsl_pkg.sv
package fbsl_pkg;

   // ------------------------------------------------------------------
   // Slave states
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      FBSL_INIT,
      FBSL_PREOP,
      FBSL_SAFEOP,
      FBSL_OP
   } fbsl_state_t;

   // ------------------------------------------------------------------
   // Pattern timing
   // ------------------------------------------------------------------
   localparam int FBSL_CLK_MHZ = 200;
   localparam int FBSL_PHASE_MS = 200;
   localparam int FBSL_PHASE_CYC = FBSL_PHASE_MS * 1000 * FBSL_CLK_MHZ;
   localparam int FBSL_PHASES = 6;
   localparam logic [2:0] FBSL_PHASE_LAST = 3'h5;
   localparam logic [2:0] FBSL_PHASE_FIRST = 3'h0;
   localparam logic [2:0] FBSL_PHASE_SECOND = 3'h2;
   localparam int FBSL_PORTS = 2;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic req;
      fbsl_state_t target;
   } fbsl_cmd_t;

   typedef struct packed {
      logic fatal;
      logic bad_config;
      logic unsolicited;
      logic wd_expired;
      logic app_fail;
   } fbsl_err_t;

   typedef struct packed {
      logic green;
      logic red;
   } fbsl_led_t;

   typedef struct packed {
      logic mailbox;
      logic tx_cyclic;
      logic rx_cyclic;
   } fbsl_svc_t;

endpackage

// File: design/fbsl_slave.sv
// Functional notes
// (R01) Two ports; either may face the master, the other forwards onward.
// (R02) Status LED: off init, solid op, blink preop, single flash safeop, red fatal.
// (R03) Error LED: off, blink bad config, one flash unsolicited, solid app failure.
// (R04) Watchdog expiry shows a red double flash on the error LED.
// (R05) Link LED off without link, solid green with link and no traffic.
// (R06) Link LED blinks green while link present and frames seen.
// (R07) Exactly four states; only the master directs transitions.
// (R08) Reset starts in Init; master normally advances to Operational.
// (R09) Init none; preop mailbox; safeop adds input data; op adds output data.
// (R10) Sent cyclic data read-only measurements; received cyclic data writable set points.
// (R11) Set points arrive via received mapping; measurements leave via sent mapping.
// (R12) Mailbox service only on master request, no timing guarantee.
// (R13) Master avoids mailbox writes to variables also mapped in output data.
// (R14) Patterns come from a free-running timer with parameterised period.
module fbsl_slave
   import fbsl_pkg::*;
#(
   parameter int PHASE_CYC = fbsl_pkg::FBSL_PHASE_CYC,
   parameter int DATA_W = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // State control from the master
   input wire fbsl_pkg::fbsl_cmd_t cmd,
   output fbsl_pkg::fbsl_state_t state,
   output fbsl_pkg::fbsl_svc_t svc_open,
   // Error sources
   input wire fbsl_pkg::fbsl_err_t err,
   // Indicators
   output fbsl_pkg::fbsl_led_t run_led,
   output fbsl_pkg::fbsl_led_t err_led,
   // Ports: link and frame activity per port
   input wire logic [fbsl_pkg::FBSL_PORTS-1:0] link_up,
   input wire logic [fbsl_pkg::FBSL_PORTS-1:0] frame_seen,
   output logic [fbsl_pkg::FBSL_PORTS-1:0] link_led_green,
   output logic [fbsl_pkg::FBSL_PORTS-1:0] upstream_port,
   // Mailbox service
   input wire logic mbx_req,
   output logic mbx_ack,
   // Received cyclic data: set points
   input wire logic rx_valid,
   input wire logic [DATA_W-1:0] rx_data,
   output logic [DATA_W-1:0] setpoint,
   // Sent cyclic data: measurements
   input wire logic [DATA_W-1:0] measurement,
   input wire logic tx_read,
   output logic tx_valid,
   output logic [DATA_W-1:0] tx_data
);
   import fbsl_pkg::*;

   // ------------------------------------------------------------------
   // State record
   // ------------------------------------------------------------------
   typedef struct packed {
      fbsl_state_t st;
      fbsl_svc_t svc;
      logic [FBSL_PORTS-1:0] upstream;
      logic mbx_ack;
      logic [DATA_W-1:0] setpoint;
      logic tx_valid;
      logic [DATA_W-1:0] tx_data;
      fbsl_led_t run_led;
      fbsl_led_t err_led;
   } fbsl_regs_t;

   fbsl_regs_t r;
   fbsl_regs_t next_r;

   logic phase_end;
   logic blink_on;
   logic flash1_on;
   logic flash2_on;

   // ------------------------------------------------------------------
   // Pattern timer and per-port link indicators
   // ------------------------------------------------------------------
   // One shared timer keeps every indicator in step with the others
   fbsl_pattern #(
      .PHASE_CYC(PHASE_CYC)
   ) u_fbsl_pattern (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .phase_end(phase_end),
      .blink_on(blink_on),
      .flash1_on(flash1_on),
      .flash2_on(flash2_on)
   );

   for (genvar i = 0; i < FBSL_PORTS; i++) begin : g_port
      fbsl_port_led u_fbsl_port_led (
         .sys_clk(sys_clk),
         .reset_n(reset_n),
         .phase_end(phase_end),
         .blink_on(blink_on),
         .link_up(link_up[i]),
         .frame_seen(frame_seen[i]),
         .led_green(link_led_green[i]) // R05 R06
      );
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      next_r = r;

      // Only master commands move the state; never self-advancing
      if (cmd.req) begin // R07
         next_r.st = cmd.target; // R08
      end

      // Gates are registered with the state so they change on the same edge
      next_r.svc.mailbox = next_r.st != FBSL_INIT; // R09
      next_r.svc.tx_cyclic = (next_r.st == FBSL_SAFEOP) || (next_r.st == FBSL_OP); // R09
      next_r.svc.rx_cyclic = next_r.st == FBSL_OP; // R09

      // First port with a link becomes the one facing the master;
      // the other then forwards. Held until that link drops.
      if ((r.upstream & link_up) == '0) begin // R01
         next_r.upstream = '0;
         for (int i = FBSL_PORTS - 1; i >= 0; i--) begin
            if (link_up[i]) begin
               next_r.upstream = '0;
               next_r.upstream[i] = 1'b1;
            end
         end
      end

      // Mailbox answered on request only, from pre-operational on
      next_r.mbx_ack = mbx_req && (r.st != FBSL_INIT); // R12 R09

      // Set points only written in operational
      if (rx_valid && r.st == FBSL_OP) begin // R09 R10 R11
         next_r.setpoint = rx_data;
      end

      // Measurements offered from safe-operational on; read-only outward
      if (r.st == FBSL_SAFEOP || r.st == FBSL_OP) begin // R09 R10 R11
         if (!r.tx_valid || tx_read) begin
            next_r.tx_data = measurement;
            next_r.tx_valid = 1'b1;
         end
      end else begin
         next_r.tx_valid = 1'b0;
      end

      // Status LED
      next_r.run_led = '0;
      if (err.fatal) begin // R02
         next_r.run_led.red = 1'b1;
      end else begin
         unique case (r.st)
            FBSL_INIT: next_r.run_led.green = 1'b0; // R02
            FBSL_PREOP: next_r.run_led.green = blink_on; // R02
            FBSL_SAFEOP: next_r.run_led.green = flash1_on; // R02
            FBSL_OP: next_r.run_led.green = 1'b1; // R02
         endcase
      end

      // Error LED: most serious condition wins
      next_r.err_led = '0;
      if (err.app_fail) begin // R03
         next_r.err_led.red = 1'b1;
      end else if (err.wd_expired) begin // R04
         next_r.err_led.red = flash2_on;
      end else if (err.unsolicited) begin // R03
         next_r.err_led.red = flash1_on;
      end else if (err.bad_config) begin // R03
         next_r.err_led.red = blink_on;
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         r <= '0;
         r.st <= FBSL_INIT; // R08
      end else begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign state = r.st;
   assign svc_open = r.svc; // R09
   assign run_led = r.run_led;
   assign err_led = r.err_led;
   assign upstream_port = r.upstream;
   assign mbx_ack = r.mbx_ack;
   assign setpoint = r.setpoint;
   assign tx_valid = r.tx_valid;
   assign tx_data = r.tx_data;

endmodule

// ------------------------------------------------------------------
// Pattern timer
// ------------------------------------------------------------------
// Six phases a period. Reset only aligns the count; nothing stalls it,
// so a pattern is never cut short by activity elsewhere in the block.
module fbsl_pattern
   import fbsl_pkg::*;
#(
   parameter int PHASE_CYC = fbsl_pkg::FBSL_PHASE_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Phase strobes
   output logic phase_end,
   output logic blink_on,
   output logic flash1_on,
   output logic flash2_on
);
   import fbsl_pkg::*;

   typedef struct packed {
      logic [31:0] tick;
      logic [2:0] phase;
   } fbsl_pat_t;

   fbsl_pat_t r;
   fbsl_pat_t next_r;

   always_comb begin
      next_r = r;
      if (phase_end) begin // R14
         next_r.tick = '0;
         next_r.phase = (r.phase == FBSL_PHASE_LAST) ? FBSL_PHASE_FIRST : r.phase + 3'h1;
      end else begin
         next_r.tick = r.tick + 32'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Double flash lights phases 0 and 2 so it cannot be mistaken for
   // the single flash or the even-phase blink.
   assign phase_end = r.tick == 32'(PHASE_CYC - 1); // R14
   assign blink_on = r.phase[0] == 1'b0; // R14
   assign flash1_on = r.phase == FBSL_PHASE_FIRST; // R14
   assign flash2_on = (r.phase == FBSL_PHASE_FIRST) || (r.phase == FBSL_PHASE_SECOND); // R04
endmodule

// ------------------------------------------------------------------
// Link indicator, one per port
// ------------------------------------------------------------------
module fbsl_port_led (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Pattern strobes
   input wire logic phase_end,
   input wire logic blink_on,
   // Port status
   input wire logic link_up,
   input wire logic frame_seen,
   // Indicator
   output logic led_green
);
   import fbsl_pkg::*;

   typedef struct packed {
      logic act;
      logic act_seen;
      logic led;
   } fbsl_port_t;

   fbsl_port_t r;
   fbsl_port_t next_r;

   // Activity is gathered over a whole phase and shown in the next one,
   // so a single short frame still blinks the LED off if the next phase is odd, at the cost
   // of up to one phase of delay.
   always_comb begin
      next_r = r;
      if (phase_end) begin
         next_r.act = r.act_seen | frame_seen; // R06
         next_r.act_seen = 1'b0;
      end else begin
         next_r.act_seen = r.act_seen | frame_seen; // R06
      end
      if (!link_up) begin // R05
         next_r.led = 1'b0;
      end else if (r.act) begin // R06
         next_r.led = blink_on;
      end else begin // R05
         next_r.led = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign led_green = r.led;
endmodule

// File: bench/fbsl_master.sv
// Master side: issues one-cycle state commands; never advances on its own
module fbsl_master
   import fbsl_pkg::*;
(
   input wire logic sys_clk,
   output fbsl_pkg::fbsl_cmd_t cmd = '0
);
   timeunit 1ns;
   timeprecision 100ps;
   import fbsl_pkg::*;
   task go(input fbsl_state_t t);
      @(posedge sys_clk);
      #1;
      cmd = '{1'b1, t};
      @(posedge sys_clk);
      #1;
      cmd.req = 1'b0;
   endtask
endmodule

// File: bench/fbsl_slave_chk.sv
module fbsl_slave_chk
   import fbsl_pkg::*;
#(
   parameter int DATA_W = 16
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire fbsl_pkg::fbsl_cmd_t cmd,
   input wire fbsl_pkg::fbsl_state_t state,
   input wire fbsl_pkg::fbsl_svc_t svc_open,
   input wire fbsl_pkg::fbsl_err_t err,
   input wire fbsl_pkg::fbsl_led_t run_led,
   input wire fbsl_pkg::fbsl_led_t err_led,
   input wire logic [1:0] link_up,
   input wire logic [1:0] link_led_green,
   input wire logic mbx_req,
   input wire logic mbx_ack,
   input wire logic rx_valid,
   input wire logic [DATA_W-1:0] rx_data,
   input wire logic [DATA_W-1:0] setpoint
);
   timeunit 1ns;
   timeprecision 100ps;
   import fbsl_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   AST_STATE: assert property (cmd.req |=> state == $past(cmd.target))
      else $error("state did not follow command");
   AST_HOLD: assert property (!cmd.req |=> $stable(state))
      else $error("state moved on its own");
   AST_SVC: assert property (svc_open == {state != FBSL_INIT, state[1], state == FBSL_OP})
      else $error("service gate wrong");
   AST_MBX: assert property (mbx_req && state != FBSL_INIT |=> mbx_ack)
      else $error("mailbox not answered");
   AST_SETP: assert property (rx_valid && state == FBSL_OP |=> setpoint == $past(rx_data))
      else $error("setpoint not taken");
   AST_OPGRN: assert property (state == FBSL_OP && !err.fatal |=> run_led == 2'h2)
      else $error("run led not solid green");
   AST_FATAL: assert property (err.fatal |=> run_led == 2'h1)
      else $error("run led not red");
   AST_ERR: assert property (err == '0 ##1 err == '0 |-> err_led == 2'h0)
      else $error("error led lit");
   AST_APPF: assert property (err.app_fail |=> err_led == 2'h1)
      else $error("error led not solid red");
   AST_LINK: assert property (!link_up[0] |=> !link_led_green[0])
      else $error("link led lit without link");
   cover property (state == FBSL_OP);
   cover property (mbx_ack);
   cover property (err.wd_expired ##1 err_led.red);
endmodule
bind fbsl_slave fbsl_slave_chk #(.DATA_W(DATA_W)) u_fbsl_slave_chk (.sys_clk, .reset_n, .cmd,
   .state, .svc_open, .err, .run_led, .err_led, .link_up, .link_led_green, .mbx_req,
   .mbx_ack, .rx_valid, .rx_data, .setpoint);

// File: bench/fbsl_slave_bench.sv
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin num_errors++; \
   $display("mismatch %s exp %0h seen %0h", n, e, s); end end
module fbsl_slave_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import fbsl_pkg::*;
   logic sys_clk = 0;
   logic reset_n = 0;
   fbsl_cmd_t cmd;
   fbsl_state_t state;
   fbsl_svc_t svc_open;
   fbsl_err_t err = '0;
   fbsl_led_t run_led, err_led;
   logic [1:0] link_up = '0, frame_seen = '0, link_led_green, upstream_port;
   logic mbx_req = 0, mbx_ack, rx_valid = 0, tx_read = 0, tx_valid;
   logic [15:0] rx_data = '0, measurement = '0, setpoint, tx_data, old;
   logic [2:0] svc_x[4] = '{3'h0, 3'h4, 3'h6, 3'h7};
   logic [4:0] ev[5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h00};
   int grn[4] = '{0, 12, 4, 24};
   int ec[5] = '{24, 8, 4, 12, 0};
   int num_errors = 0, comparisons = 0, cyc = 0, cnt, exp_cnt;
   int q[$];
   event done;
   always #2.5 sys_clk = ~sys_clk;
   fbsl_master u_fbsl_master (.sys_clk, .cmd);
   fbsl_slave #(.PHASE_CYC(4)) u_fbsl_slave (.sys_clk, .reset_n, .cmd, .state, .svc_open,
      .err, .run_led, .err_led, .link_up, .frame_seen, .link_led_green, .upstream_port,
      .mbx_req, .mbx_ack, .rx_valid, .rx_data, .setpoint, .measurement, .tx_read,
      .tx_valid, .tx_data);
   task tally_and_finish;
      if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task step(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Lit cycles over one full 24-cycle pattern, after a settling gap
   task meas(int s, int e);
      q.push_back(e);
      step(30);
      cnt = 0;
      repeat (24) begin
         cnt += ({run_led.green, run_led.red, err_led.red, link_led_green} >> (4 - s)) & 1;
         step(1);
      end
      ->done;
   endtask
   always @(done) begin
      exp_cnt = q.pop_front();
      `CHK("lit_cycles", exp_cnt, cnt)
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 3000) begin
         num_errors++;
         tally_and_finish;
      end
   end
   initial begin
      cnt = $urandom(11);
      step(2);
      reset_n = 1;
      step(1);
      `CHK("state", FBSL_INIT, state)
      mbx_req = 1;
      step(1);
      `CHK("ack", 1'b0, mbx_ack)
      mbx_req = 0;
      meas(0, 0);
      for (int i = 1; i < 4; i++) begin
         u_fbsl_master.go(fbsl_state_t'(i));
         `CHK("state", i, state)
         `CHK("svc", svc_x[i], svc_open)
         mbx_req = 1;
         step(1);
         `CHK("ack", 1'b1, mbx_ack)
         mbx_req = 0;
         meas(0, grn[i]);
      end
      rx_valid = 1;
      repeat (4) begin
         rx_data = 16'($urandom);
         step(1);
         `CHK("setpoint", rx_data, setpoint)
      end
      rx_valid = 0;
      measurement = 16'($urandom);
      tx_read = 1;
      step(2);
      `CHK("tx_data", measurement, tx_data)
      `CHK("tx_valid", 1'b1, tx_valid)
      tx_read = 0;
      u_fbsl_master.go(FBSL_SAFEOP);
      old = rx_data;
      rx_data = ~old;
      rx_valid = 1;
      step(2);
      rx_valid = 0;
      `CHK("setpoint", old, setpoint)
      err.fatal = 1;
      meas(1, 24);
      for (int k = 0; k < 5; k++) begin
         err = ev[k];
         meas(2, ec[k]);
      end
      link_up = 2'h3;
      meas(3, 24);
      frame_seen = 2'h3;
      meas(4, 12);
      frame_seen = 2'h0;
      link_up = 2'h2;
      step(2);
      `CHK("upstream", 2'h2, upstream_port)
      meas(4, 0);
      u_fbsl_master.go(FBSL_INIT);
      `CHK("state", FBSL_INIT, state)
      tally_and_finish;
   end
endmodule
